// ==== include/parallel_config_load_regs.svh ====
// timing counts, field positions and register offsets of the parallel load link
`ifndef PARALLEL_CONFIG_LOAD_REGS_SVH
`define PARALLEL_CONFIG_LOAD_REGS_SVH
`define CLK_MHZ 100
`define T_CF2CD_NS 600
`define T_REQ_LOW_US 2
`define T_STATUS_MIN_US 268
`define T_CF2CK_US 1506
`define T_ST2CK_US 2
`define T_CD2UM_MIN_US 175
`define LOAD_CLOCK_MAX_PERIOD_NS 10
`define CD2CU_PERIODS 4
`define INIT_USER_CLOCKS 8576
`define FINISH_FALLS 2
`define LOAD_HALF_CYC 5
`define OPT_INIT_DONE_BIT 0
`define OPT_USER_CLK_BIT 1
`define AV_CTRL 4'h0
`define AV_STATUS 4'h4
`define AV_DATA 4'h8
`define CTRL_START_BIT 0
`define CTRL_MONITOR_BIT 1
`define ST_STATUS_BIT 0
`define ST_COMPLETE_BIT 1
`define ST_READY_BIT 2
`define ST_DONE_BIT 3
`define ST_ERROR_BIT 4
`define ST_BUSY_BIT 5
`endif

// ==== include/parallel_config_load_pkg.sv ====
// state and bus-width types of the host and device ends of the parallel load link
package parallel_config_load_pkg;
   typedef enum logic [1:0] {
      SCHEME_X8 = 2'h0,
      SCHEME_X16 = 2'h1,
      SCHEME_X32 = 2'h2
   } scheme_type;
   typedef enum logic [5:0] {
      D_POR = 6'h01,
      D_RESET = 6'h02,
      D_LOAD = 6'h04,
      D_FINISH = 6'h08,
      D_INIT = 6'h10,
      D_USER = 6'h20
   } dev_state_type;
   typedef enum logic [7:0] {
      H_IDLE = 8'h01,
      H_REQ = 8'h02,
      H_WAIT = 8'h04,
      H_READY = 8'h08,
      H_CLKLO = 8'h10,
      H_CLKHI = 8'h20,
      H_FINISH = 8'h40,
      H_DONE = 8'h80
   } host_state_type;
endpackage

// ==== include/config_link_if.sv ====
// pin bundle between the load host and the configured device
`timescale 1ns/1ps
`default_nettype none
interface config_link_if;
   logic config_request_n;
   logic load_clock;
   logic [31:0] load_data;
   logic load_status_n_o;
   logic load_status_n_oe;
   logic load_complete_o;
   logic load_complete_oe;
   logic init_done_o;
   logic init_done_oe;
   logic chain_enable_out_n;
   // open-drain lines with pull-ups
   logic load_status_n;
   logic load_complete;
   logic init_done;
   assign load_status_n = load_status_n_oe ? load_status_n_o : 1'b1;
   assign load_complete = load_complete_oe ? load_complete_o : 1'b1;
   assign init_done = init_done_oe ? init_done_o : 1'b1;
   modport device (
      input config_request_n, load_clock, load_data,
      output load_status_n_o, load_status_n_oe, load_complete_o, load_complete_oe,
      output init_done_o, init_done_oe, chain_enable_out_n
   );
   modport host (
      output config_request_n, load_clock, load_data,
      input load_status_n, load_complete, init_done
   );
endinterface
`default_nettype wire

// ==== rtl/config_load_device.sv ====
// device end of the parallel configuration load port
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_load_regs.svh"
module config_load_device
   import parallel_config_load_pkg::*;
#(
   parameter int IMAGE_WORDS = 16,
   parameter int STATUS_HOLD_CYC = `T_STATUS_MIN_US * `CLK_MHZ,
   parameter int INIT_CYC = `T_CD2UM_MIN_US * `CLK_MHZ,
   parameter int INIT_USER_CLOCKS = `INIT_USER_CLOCKS
) (
   input wire logic clk_i,
   input wire logic srst_i,
   config_link_if.device link,
   input wire logic [1:0] scheme_select_i,
   input wire logic user_init_clock_i,
   output logic [31:0] config_word_o,
   output logic config_word_valid_o,
   output logic user_mode_o
);
   localparam int CU_CYC = (`CD2CU_PERIODS * `LOAD_CLOCK_MAX_PERIOD_NS * `CLK_MHZ + 999) / 1000;

   // ==========================================
   // input synchronisers
   logic [36:0] sync1_q;
   logic [36:0] sync2_q;
   logic clk_prev_q;
   logic uclk_prev_q;
   always_ff @(posedge clk_i) begin
      sync1_q <= {link.config_request_n, link.load_clock, user_init_clock_i, scheme_select_i,
         link.load_data};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[35];
      uclk_prev_q <= sync2_q[34];
   end
   logic req_s;
   logic lclk_s;
   logic uclk_s;
   logic [1:0] scheme_s;
   logic [31:0] data_s;
   assign req_s = sync2_q[36];
   assign lclk_s = sync2_q[35];
   assign uclk_s = sync2_q[34];
   assign scheme_s = sync2_q[33:32];
   assign data_s = sync2_q[31:0];
   logic lclk_rise;
   logic lclk_fall;
   logic uclk_rise;
   assign lclk_rise = lclk_s && !clk_prev_q;
   assign lclk_fall = !lclk_s && clk_prev_q;
   assign uclk_rise = uclk_s && !uclk_prev_q;

   // ==========================================
   // bus width masking
   logic [31:0] word;
   always_comb begin
      case (scheme_type'(scheme_s))
         SCHEME_X8: word = {24'h000000, data_s[7:0]};
         SCHEME_X16: word = {16'h0000, data_s[15:0]};
         default: word = data_s;
      endcase
   end

   // ==========================================
   // load sequencer
   dev_state_type state_q;
   logic [31:0] cnt_q;
   logic [31:0] ucnt_q;
   logic [31:0] word_cnt_q;
   logic [31:0] chk_q;
   logic [1:0] falls_q;
   logic error_q;
   logic opt_init_done_q;
   logic opt_user_clk_q;
   logic last_word;
   assign last_word = word_cnt_q == 32'(IMAGE_WORDS - 1);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= D_POR;
         cnt_q <= 32'h0;
         ucnt_q <= 32'h0;
         word_cnt_q <= 32'h0;
         chk_q <= 32'h0;
         falls_q <= 2'h0;
         error_q <= 1'b0;
         opt_init_done_q <= 1'b0;
         opt_user_clk_q <= 1'b0;
      end else if (!req_s && state_q != D_RESET && state_q != D_POR) begin
         state_q <= D_RESET;
         cnt_q <= 32'h0;
      end else begin
         case (state_q)
            D_POR, D_RESET: begin
               if (cnt_q < 32'(STATUS_HOLD_CYC)) begin
                  cnt_q <= cnt_q + 32'h1;
               end
               if (!req_s) begin
                  error_q <= 1'b0;
               end
               if (cnt_q >= 32'(STATUS_HOLD_CYC) && req_s && !error_q) begin
                  state_q <= D_LOAD;
                  word_cnt_q <= 32'h0;
                  chk_q <= 32'h0;
               end
            end
            D_LOAD: begin
               if (lclk_rise) begin
                  chk_q <= chk_q ^ word;
                  word_cnt_q <= word_cnt_q + 32'h1;
                  if (word_cnt_q == 32'h0) begin
                     opt_init_done_q <= word[`OPT_INIT_DONE_BIT];
                     opt_user_clk_q <= word[`OPT_USER_CLK_BIT];
                  end
                  if (last_word) begin
                     if ((chk_q ^ word) == 32'h0) begin
                        state_q <= D_FINISH;
                        falls_q <= 2'h0;
                     end else begin
                        state_q <= D_RESET;
                        error_q <= 1'b1;
                        cnt_q <= 32'h0;
                     end
                  end
               end
            end
            D_FINISH: begin
               if (lclk_fall) begin
                  falls_q <= falls_q + 2'h1;
                  if (falls_q == 2'(`FINISH_FALLS - 1)) begin
                     state_q <= D_INIT;
                     cnt_q <= 32'h0;
                     ucnt_q <= 32'h0;
                  end
               end
            end
            D_INIT: begin
               if (!opt_user_clk_q) begin
                  cnt_q <= cnt_q + 32'h1;
                  if (cnt_q >= 32'(INIT_CYC - 1)) begin
                     state_q <= D_USER;
                  end
               end else if (cnt_q < 32'(CU_CYC)) begin
                  cnt_q <= cnt_q + 32'h1;
               end else if (uclk_rise) begin
                  ucnt_q <= ucnt_q + 32'h1;
                  if (ucnt_q == 32'(INIT_USER_CLOCKS - 1)) begin
                     state_q <= D_USER;
                  end
               end
            end
            default: begin
               state_q <= D_USER;
            end
         endcase
      end
   end

   // ==========================================
   // pin and user outputs
   logic status_oe_q;
   logic complete_oe_q;
   logic init_oe_q;
   logic chain_n_q;
   logic [31:0] word_q;
   logic word_valid_q;
   logic user_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         status_oe_q <= 1'b1;
         complete_oe_q <= 1'b1;
         init_oe_q <= 1'b0;
         chain_n_q <= 1'b1;
         user_q <= 1'b0;
         word_valid_q <= 1'b0;
         word_q <= 32'h0;
      end else begin
         status_oe_q <= !req_s || state_q == D_POR || state_q == D_RESET;
         complete_oe_q <= !req_s || state_q == D_POR || state_q == D_RESET
            || state_q == D_LOAD;
         init_oe_q <= req_s && opt_init_done_q
            && (state_q == D_FINISH || state_q == D_INIT);
         chain_n_q <= !(req_s && state_q == D_USER);
         user_q <= req_s && state_q == D_USER;
         word_valid_q <= req_s && state_q == D_LOAD && lclk_rise;
         if (state_q == D_LOAD && lclk_rise) begin
            word_q <= word;
         end
      end
   end
   assign link.load_status_n_o = 1'b0;
   assign link.load_status_n_oe = status_oe_q;
   assign link.load_complete_o = 1'b0;
   assign link.load_complete_oe = complete_oe_q;
   assign link.init_done_o = 1'b0;
   assign link.init_done_oe = init_oe_q;
   assign link.chain_enable_out_n = chain_n_q;
   assign config_word_o = word_q;
   assign config_word_valid_o = word_valid_q;
   assign user_mode_o = user_q;
endmodule
`default_nettype wire

// ==== rtl/config_load_host.sv ====
// host end: drives the load link on orders given over avalon-mm
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_load_regs.svh"
module config_load_host
   import parallel_config_load_pkg::*;
#(
   parameter int REQ_CYC = `T_REQ_LOW_US * `CLK_MHZ,
   parameter int CF2CK_CYC = `T_CF2CK_US * `CLK_MHZ,
   parameter int ST2CK_CYC = `T_ST2CK_US * `CLK_MHZ,
   parameter int HALF_CYC = `LOAD_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   config_link_if.host link,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   // ==========================================
   // synchronisers for device lines
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   always_ff @(posedge clk_i) begin
      sync1_q <= {link.load_status_n, link.load_complete, link.init_done};
      sync2_q <= sync1_q;
   end
   logic status_s;
   logic complete_s;
   assign status_s = sync2_q[2];
   assign complete_s = sync2_q[1];

   // ==========================================
   // avalon slave
   host_state_type state_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic monitor_q;
   logic error_q;
   logic pending;
   logic data_take;
   logic start_take;
   logic ready_for_data;
   assign pending = (avs_read_i || avs_write_i) && wait_q;
   assign ready_for_data = state_q == H_READY && !complete_s;
   assign data_take = pending && avs_write_i && avs_address_i == `AV_DATA && ready_for_data;
   assign start_take = pending && avs_write_i && avs_address_i == `AV_CTRL
      && avs_writedata_i[`CTRL_START_BIT];
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
         monitor_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
         if (pending) begin
            if (avs_address_i == `AV_DATA && avs_write_i) begin
               wait_q <= !ready_for_data;
            end else begin
               wait_q <= 1'b0;
            end
            rdata_q <= 32'h0;
            if (avs_address_i == `AV_CTRL) begin
               if (avs_write_i) begin
                  monitor_q <= avs_writedata_i[`CTRL_MONITOR_BIT];
               end
               rdata_q[`CTRL_MONITOR_BIT] <= monitor_q;
            end else if (avs_address_i == `AV_STATUS) begin
               rdata_q[`ST_STATUS_BIT] <= status_s;
               rdata_q[`ST_COMPLETE_BIT] <= complete_s;
               rdata_q[`ST_READY_BIT] <= ready_for_data;
               rdata_q[`ST_DONE_BIT] <= state_q == H_DONE;
               rdata_q[`ST_ERROR_BIT] <= error_q;
               rdata_q[`ST_BUSY_BIT] <= state_q != H_IDLE && state_q != H_DONE;
            end
         end
      end
   end
   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;

   // ==========================================
   // link sequencer
   logic [31:0] cnt_q;
   logic [1:0] falls_q;
   logic req_n_q;
   logic lclk_q;
   logic [31:0] data_q;
   logic half_done;
   assign half_done = cnt_q >= 32'(HALF_CYC - 1);
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= H_IDLE;
         cnt_q <= 32'h0;
         falls_q <= 2'h0;
         req_n_q <= 1'b1;
         lclk_q <= 1'b0;
         data_q <= 32'h0;
         error_q <= 1'b0;
      end else if (start_take) begin
         state_q <= H_REQ;
         req_n_q <= 1'b0;
         lclk_q <= 1'b0;
         cnt_q <= 32'h0;
         error_q <= 1'b0;
      end else begin
         case (state_q)
            H_REQ: begin
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q >= 32'(REQ_CYC - 1)) begin
                  req_n_q <= 1'b1;
                  state_q <= H_WAIT;
                  cnt_q <= 32'h0;
               end
            end
            H_WAIT: begin
               cnt_q <= cnt_q + 32'h1;
               if (monitor_q && !status_s) begin
                  cnt_q <= 32'h0;
               end else if (monitor_q ? cnt_q >= 32'(ST2CK_CYC)
                     : cnt_q >= 32'(CF2CK_CYC)) begin
                  state_q <= H_READY;
               end
            end
            H_READY: begin
               if (!status_s) begin
                  error_q <= 1'b1;
                  state_q <= H_IDLE;
               end else if (complete_s) begin
                  state_q <= H_FINISH;
                  falls_q <= 2'h0;
                  cnt_q <= 32'h0;
               end else if (data_take) begin
                  data_q <= avs_writedata_i;
                  state_q <= H_CLKLO;
                  cnt_q <= 32'h0;
               end
            end
            H_CLKLO: begin
               cnt_q <= cnt_q + 32'h1;
               if (half_done) begin
                  lclk_q <= 1'b1;
                  state_q <= H_CLKHI;
                  cnt_q <= 32'h0;
               end
            end
            H_CLKHI: begin
               cnt_q <= cnt_q + 32'h1;
               if (half_done) begin
                  lclk_q <= 1'b0;
                  state_q <= H_READY;
                  cnt_q <= 32'h0;
               end
            end
            H_FINISH: begin
               cnt_q <= cnt_q + 32'h1;
               if (half_done) begin
                  cnt_q <= 32'h0;
                  lclk_q <= !lclk_q;
                  if (lclk_q) begin
                     falls_q <= falls_q + 2'h1;
                     if (falls_q == 2'(`FINISH_FALLS - 1)) begin
                        state_q <= H_DONE;
                     end
                  end
               end
            end
            default: begin
               lclk_q <= 1'b0;
            end
         endcase
      end
   end
   assign link.config_request_n = req_n_q;
   assign link.load_clock = lclk_q;
   assign link.load_data = data_q;
endmodule
`default_nettype wire

// ==== bench/parallel_config_load_port_properties.sv ====
// concurrent checks on the pins between load host and configured device
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load_port_properties #(
   parameter int STATUS_HOLD_CYC = 50,
   parameter int INIT_CYC = 40
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic config_request_n,
   input wire logic load_clock,
   input wire logic load_status_n,
   input wire logic load_complete,
   input wire logic init_done,
   input wire logic chain_enable_out_n
);
   // 600 ns at 100 MHz
   localparam int CF2CD_CYC = 60;
   localparam int ST_RISE_MAX = STATUS_HOLD_CYC + 10;
   logic [15:0] low_cnt_q;
   logic [15:0] cd_cnt_q;
   // ==========================================
   // helper counters
   always_ff @(posedge clk_i) begin
      if (srst_i || load_status_n) begin
         low_cnt_q <= 16'h0000;
      end else if (low_cnt_q != 16'hffff) begin
         low_cnt_q <= low_cnt_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i || !load_complete) begin
         cd_cnt_q <= 16'h0000;
      end else if (cd_cnt_q != 16'hffff) begin
         cd_cnt_q <= cd_cnt_q + 16'h0001;
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_complete_low_fast: assert property (
      $fell(config_request_n) |-> ##[1:CF2CD_CYC] !load_complete)
      else $error("complete not low soon after request");
   a_status_low_fast: assert property (
      $fell(config_request_n) |-> ##[1:CF2CD_CYC] !load_status_n)
      else $error("status not low soon after request");
   a_status_hold_min: assert property (
      $rose(load_status_n) |-> low_cnt_q >= STATUS_HOLD_CYC - 2)
      else $error("status low pulse too short");
   a_status_rise_bound: assert property (
      $rose(config_request_n) && !load_status_n |-> ##[1:ST_RISE_MAX] load_status_n)
      else $error("status not released after request high");
   a_complete_rise_cause: assert property (
      $rose(load_complete) |-> load_status_n && config_request_n)
      else $error("complete rose during a faulty load");
   a_init_time_min: assert property (
      $fell(chain_enable_out_n) |-> cd_cnt_q >= INIT_CYC)
      else $error("user mode entered too early");
   a_init_done_user: assert property (
      !chain_enable_out_n |-> init_done)
      else $error("init done low in user mode");
   a_user_lines_high: assert property (
      !chain_enable_out_n && config_request_n |-> load_complete && load_status_n)
      else $error("user mode lines not high");
   a_clock_ignored: assert property (
      !chain_enable_out_n && $changed(load_clock) |=> load_complete)
      else $error("load clock disturbed completed device");
endmodule
`default_nettype wire

// ==== bench/parallel_config_load_port_tb.sv ====
// self-checking bench joining load host and device
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_load_regs.svh"
module parallel_config_load_port_tb;
   import parallel_config_load_pkg::*;
   typedef struct packed {
      scheme_type sch;
      logic mon;
      logic [1:0] opts;
      logic [31:0] mask;
   } row_type;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic user_init_clock_i = 1'b0;
   logic [1:0] scheme_select_i = 2'h0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [31:0] config_word_o;
   logic config_word_valid_o;
   logic user_mode_o;
   int bad_count = 0;
   int checked = 0;
   int init_low_cnt = 0;
   logic [31:0] got_q[$];
   row_type rows [4] = '{
      '{SCHEME_X8, 1'b0, 2'h0, 32'h0000_00ff},
      '{SCHEME_X16, 1'b1, 2'h1, 32'h0000_ffff},
      '{SCHEME_X32, 1'b1, 2'h2, 32'hffff_ffff},
      '{scheme_type'(2'h3), 1'b0, 2'h3, 32'hffff_ffff}};
   // ==========================================
   // clocks and instances
   always #5 clk_i = ~clk_i;
   initial begin
      #3;
      forever #80 user_init_clock_i = ~user_init_clock_i;
   end
   config_link_if link();
   config_load_host #(.CF2CK_CYC(300)) i_config_load_host (
      .clk_i(clk_i), .srst_i(srst_i), .link(link),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o));
   config_load_device #(.IMAGE_WORDS(4), .STATUS_HOLD_CYC(50), .INIT_CYC(40),
      .INIT_USER_CLOCKS(8)) i_config_load_device (
      .clk_i(clk_i), .srst_i(srst_i), .link(link), .scheme_select_i(scheme_select_i),
      .user_init_clock_i(user_init_clock_i), .config_word_o(config_word_o),
      .config_word_valid_o(config_word_valid_o), .user_mode_o(user_mode_o));
   parallel_config_load_port_properties i_parallel_config_load_port_properties (
      .clk_i(clk_i), .srst_i(srst_i), .config_request_n(link.config_request_n),
      .load_clock(link.load_clock), .load_status_n(link.load_status_n),
      .load_complete(link.load_complete), .init_done(link.init_done),
      .chain_enable_out_n(link.chain_enable_out_n));
   always @(posedge clk_i) begin
      if (config_word_valid_o === 1'b1) begin
         got_q.push_back(config_word_o);
      end
      if (link.init_done === 1'b0) begin
         init_low_cnt++;
      end
   end
   // ==========================================
   // compare, bus, load-run and closing tasks
   task automatic cmp_word(input string name, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic cmp_bit(input string name, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", name, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20000);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (n >= 20000) begin
         bad_count++;
         $display("ERROR avalon answer expected 1 seen 0");
      end
   endtask
   task automatic run_cfg(input row_type r, input logic good);
      logic [31:0] w [4];
      logic [31:0] rd;
      int k;
      int n0;
      n0 = init_low_cnt;
      w[0] = 32'hc3a5_9600 | {30'h0, r.opts};
      w[1] = 32'h1234_5678;
      w[2] = 32'h89ab_cdef;
      w[3] = w[0] ^ w[1] ^ w[2] ^ {31'h0, !good};
      scheme_select_i <= r.sch;
      got_q.delete();
      av_xfer(1'b1, `AV_CTRL, {30'h0, r.mon, 1'b1}, rd);
      av_xfer(1'b0, `AV_CTRL, 32'h0, rd);
      cmp_bit("monitor bit", r.mon, rd[`CTRL_MONITOR_BIT]);
      for (int i = 0; i < 4; i++) begin
         av_xfer(1'b1, `AV_DATA, w[i], rd);
      end
      k = 0;
      do begin
         av_xfer(1'b0, `AV_STATUS, 32'h0, rd);
         k++;
      end while (rd[`ST_DONE_BIT] !== 1'b1 && rd[`ST_ERROR_BIT] !== 1'b1 && k < 2000);
      k = 0;
      while (good && user_mode_o !== 1'b1 && k < 1000) begin
         @(posedge clk_i);
         k++;
      end
      cmp_bit("done", good, rd[`ST_DONE_BIT]);
      cmp_bit("error", !good, rd[`ST_ERROR_BIT]);
      cmp_bit("user mode", good, user_mode_o);
      cmp_bit("status line", good, link.load_status_n);
      cmp_bit("chain out", !good, link.chain_enable_out_n);
      cmp_bit("init done low", good & r.opts[0], init_low_cnt != n0);
      cmp_word("word count", 32'h4, 32'(got_q.size()));
      for (int i = 0; i < 4; i++) begin
         if (i < got_q.size()) begin
            cmp_word("captured word", w[i] & r.mask, got_q[i]);
         end
      end
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      logic [31:0] rd;
      repeat (16) @(posedge clk_i);
      cmp_bit("status in reset", 1'b0, link.load_status_n);
      cmp_bit("complete in reset", 1'b0, link.load_complete);
      srst_i <= 1'b0;
      av_xfer(1'b1, 4'hc, 32'hffff_ffff, rd);
      av_xfer(1'b0, 4'hc, 32'h0, rd);
      cmp_word("unmapped read", 32'h0, rd);
      foreach (rows[i]) begin
         run_cfg(rows[i], 1'b1);
      end
      run_cfg(rows[0], 1'b0);
      run_cfg(rows[2], 1'b1);
      av_xfer(1'b1, `AV_CTRL, 32'h1, rd);
      av_xfer(1'b1, `AV_DATA, 32'h1, rd);
      srst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      cmp_bit("user mode in reset", 1'b0, user_mode_o);
      cmp_bit("status in reset", 1'b0, link.load_status_n);
      srst_i <= 1'b0;
      run_cfg(rows[3], 1'b1);
      tally_and_finish();
   end
   initial begin
      #800000;
      bad_count++;
      $display("ERROR watchdog expected end seen hang");
      tally_and_finish();
   end
endmodule
`default_nettype wire
